// ### led_seq_pkg.sv
// shared constants and types of the indicator sequencer
package led_seq_pkg;

   // ------------------------------------------------------------
   // clock and time base
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS = 4000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = TICK_US * 1000000 / CLK_PERIOD_PS;

   // ------------------------------------------------------------
   // blink timing in milliseconds
   // ------------------------------------------------------------
   localparam logic [11:0] BLINK5_HALF_MS = 12'h064;
   localparam logic [11:0] BLINK1_HALF_MS = 12'h1F4;
   localparam logic [11:0] STEP_MS = 12'h0FA;
   localparam logic [11:0] CODE_ON_MS = 12'h0C8;
   localparam logic [11:0] CODE_OFF_MS = 12'h0C8;
   localparam logic [11:0] DIGIT_PAUSE_MS = 12'h320;
   localparam logic [11:0] CODE_GAP_MS = 12'h7D0;
   localparam logic [7:0] ACT_PERIOD_MS = 8'hC8;
   localparam logic [7:0] ACT_DARK_MS = 8'h64;
   localparam logic [7:0] ERR_BLINK_MS = 8'hC8;

   // ------------------------------------------------------------
   // led colours
   // ------------------------------------------------------------
   localparam logic [1:0] COL_OFF = 2'h0;
   localparam logic [1:0] COL_GREEN = 2'h1;
   localparam logic [1:0] COL_YELLOW = 2'h2;
   localparam logic [1:0] COL_ORANGE = 2'h3;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATE = 12'h004;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h008;
   localparam logic [11:0] OFS_IRQ_CLEAR = 12'h00C;
   localparam logic [11:0] OFS_IRQ_ENABLE = 12'h010;
   localparam int CTRL_READY_BIT = 0;
   localparam int CTRL_MONITOR_BIT = 1;
   localparam int IRQ_OPER_BIT = 0;
   localparam int IRQ_MONITOR_BIT = 1;
   localparam int IRQ_HUB_BIT = 2;
   localparam int IRQ_SERIAL_BIT = 3;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ------------------------------------------------------------
   // state types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_SELFTEST, ST_OPER, ST_MONITOR} ind_state_t;
   typedef enum logic [1:0] {CG_IDLE, CG_ON, CG_OFF, CG_PAUSE} code_state_t;

endpackage

// ### blink_code_if.sv
// link between the sequencer and the error code blinker
`timescale 1ns/1ps
interface blink_code_if;
   logic tick;
   logic enable;
   logic [7:0] code;
   logic led_on;
   modport gen (input tick, input enable, input code, output led_on);
   modport user (output tick, output enable, output code, input led_on);
endinterface

// ### blink_code_gen.sv
// two digit hex error code blinker
`timescale 1ns/1ps
module blink_code_gen (
   input wire logic aclk,
   input wire logic aresetn,
   blink_code_if.gen bus
);

   led_seq_pkg::code_state_t state_reg, state_next;
   logic dig_reg, dig_next;
   logic [3:0] left_reg, left_next;
   logic [11:0] tmr_reg, tmr_next;
   logic led_reg;

   wire expire = bus.tick && (tmr_reg == 12'h000);
   wire [3:0] new_digit = dig_reg ? bus.code[7:4] : bus.code[3:0];
   wire [11:0] end_pause = dig_reg ? led_seq_pkg::CODE_GAP_MS : led_seq_pkg::DIGIT_PAUSE_MS;
   wire [11:0] skip_pause = dig_reg ? led_seq_pkg::DIGIT_PAUSE_MS : led_seq_pkg::CODE_GAP_MS;

   // first digit, pause, second digit, long gap, again
   always_comb begin
      state_next = state_reg;
      dig_next = dig_reg;
      left_next = left_reg;
      tmr_next = (bus.tick && tmr_reg != 12'h000) ? tmr_reg - 12'h001 : tmr_reg;
      case (state_reg)
         led_seq_pkg::CG_IDLE: begin
            dig_next = 1'b1;
            tmr_next = 12'h000;
            if (bus.enable) begin
               state_next = led_seq_pkg::CG_PAUSE;
            end
         end
         led_seq_pkg::CG_ON: begin
            if (expire && left_reg != 4'h0) begin
               state_next = led_seq_pkg::CG_OFF;
               tmr_next = led_seq_pkg::CODE_OFF_MS - 12'h001;
            end else if (expire) begin
               state_next = led_seq_pkg::CG_PAUSE;
               tmr_next = end_pause - 12'h001;
            end
         end
         led_seq_pkg::CG_OFF: begin
            if (expire) begin
               state_next = led_seq_pkg::CG_ON;
               left_next = left_reg - 4'h1;
               tmr_next = led_seq_pkg::CODE_ON_MS - 12'h001;
            end
         end
         led_seq_pkg::CG_PAUSE: begin
            if (expire) begin
               dig_next = ~dig_reg;
               if (new_digit != 4'h0) begin
                  state_next = led_seq_pkg::CG_ON;
                  left_next = new_digit - 4'h1;
                  tmr_next = led_seq_pkg::CODE_ON_MS - 12'h001;
               end else begin
                  tmr_next = skip_pause - 12'h001;
               end
            end
         end
         default: begin
            state_next = led_seq_pkg::CG_IDLE;
         end
      endcase
      if (!bus.enable) begin
         state_next = led_seq_pkg::CG_IDLE;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= led_seq_pkg::CG_IDLE;
         dig_reg <= 1'b1;
         left_reg <= 4'h0;
         tmr_reg <= 12'h000;
         led_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         dig_reg <= dig_next;
         left_reg <= left_next;
         tmr_reg <= tmr_next;
         led_reg <= (state_next == led_seq_pkg::CG_ON);
      end
   end

   assign bus.led_on = led_reg;

endmodule

// ### status_led_indicator_sequencer.sv
// front panel indicator sequencer with axi4-lite registers
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module status_led_indicator_sequencer #(
   parameter int HUB_PORTS = 4,
   parameter int SERIAL_PORTS = 8,
   parameter int ADDR_W = 12,
   parameter int TICK_CYCLES = led_seq_pkg::TICK_CYCLES
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic selftest_done,
   input wire logic selftest_fatal,
   input wire logic [7:0] fatal_code,
   input wire logic debug_button,
   input wire logic cfg_fallback,
   input wire logic hub_fail,
   input wire logic [HUB_PORTS-1:0] hub_selftest_err,
   input wire logic [HUB_PORTS-1:0] hub_rate_err,
   input wire logic [HUB_PORTS-1:0] hub_polarity_err,
   input wire logic [HUB_PORTS-1:0] hub_link,
   input wire logic [SERIAL_PORTS-1:0] serial_selftest_err,
   input wire logic [SERIAL_PORTS-1:0] serial_open,
   input wire logic [SERIAL_PORTS-1:0] serial_activity,
   input wire logic [SERIAL_PORTS-1:0] serial_line_err,
   input wire logic [SERIAL_PORTS-1:0] serial_op_err,
   output logic [1:0] unit_led,
   output logic [2*HUB_PORTS-1:0] hub_led,
   output logic [2*SERIAL_PORTS-1:0] serial_led,
   output logic irq
);

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   function automatic logic [2:0] reg_index(input logic [ADDR_W-1:0] addr);
      logic [11:0] a;
      a = 12'(addr);
      case (a)
         led_seq_pkg::OFS_CTRL: reg_index = 3'h1;
         led_seq_pkg::OFS_STATE: reg_index = 3'h2;
         led_seq_pkg::OFS_IRQ_STATUS: reg_index = 3'h3;
         led_seq_pkg::OFS_IRQ_CLEAR: reg_index = 3'h4;
         led_seq_pkg::OFS_IRQ_ENABLE: reg_index = 3'h5;
         default: reg_index = 3'h0;
      endcase
   endfunction

   // ------------------------------------------------------------
   // bus slave state
   // ------------------------------------------------------------
   logic awready_reg, wready_reg, bvalid_reg, arready_reg, rvalid_reg;
   logic [ADDR_W-1:0] awaddr_reg;
   logic [31:0] wdata_reg, rdata_reg;
   logic [3:0] wstrb_reg;
   logic [1:0] bresp_reg, rresp_reg;
   logic [1:0] ctrl_reg;
   logic [3:0] irq_status_reg, irq_enable_reg;
   logic irq_reg;

   wire do_write = !awready_reg && !wready_reg && !bvalid_reg;
   wire [2:0] wr_idx = reg_index(awaddr_reg);
   wire [2:0] rd_idx = reg_index(s_axi_araddr);
   wire wr_lane0 = do_write && wstrb_reg[0];
   wire wr_ctrl = wr_lane0 && (wr_idx == 3'h1);
   wire wr_clear = wr_lane0 && (wr_idx == 3'h4);
   wire wr_enable = wr_lane0 && (wr_idx == 3'h5);
   wire wr_ok = (wr_idx == 3'h1) || (wr_idx == 3'h4) || (wr_idx == 3'h5);
   wire rd_take = s_axi_arvalid && arready_reg;

   // ------------------------------------------------------------
   // millisecond tick and blink phases
   // ------------------------------------------------------------
   logic [31:0] tick_cnt_reg;
   logic tick_reg;
   logic [2:0] phase_reg;
   logic [2:0] phase_wrap;
   logic [1:0] step_reg;
   localparam logic [11:0] PHASE_LEN [3] = '{led_seq_pkg::BLINK5_HALF_MS,
      led_seq_pkg::BLINK1_HALF_MS, led_seq_pkg::STEP_MS};

   wire tick_end = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick_cnt_reg <= 32'h00000000;
         tick_reg <= 1'b0;
         step_reg <= 2'h0;
      end else begin
         tick_cnt_reg <= tick_end ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
         tick_reg <= tick_end;
         step_reg <= phase_wrap[2] ? step_reg + 2'h1 : step_reg;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 3; g++) begin : g_phase
         logic [11:0] cnt_reg;
         logic ph_reg;
         assign phase_wrap[g] = tick_reg && (cnt_reg == PHASE_LEN[g] - 12'h001);
         assign phase_reg[g] = ph_reg;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               cnt_reg <= 12'h000;
               ph_reg <= 1'b0;
            end else begin
               cnt_reg <= phase_wrap[g] ? 12'h000 : (tick_reg ? cnt_reg + 12'h001 : cnt_reg);
               ph_reg <= phase_wrap[g] ? ~ph_reg : ph_reg;
            end
         end
      end
   endgenerate

   wire blink5 = phase_reg[0];
   wire blink1 = phase_reg[1];

   // ------------------------------------------------------------
   // operating state
   // ------------------------------------------------------------
   led_seq_pkg::ind_state_t state_reg, state_next;
   logic fatal_reg;
   logic [7:0] code_reg;
   logic debug_d_reg, hub_fail_d_reg;

   wire debug_press = debug_button && !debug_d_reg;
   wire force_mon = debug_press || ctrl_reg[led_seq_pkg::CTRL_MONITOR_BIT];
   wire fatal_hit = (state_reg == led_seq_pkg::ST_SELFTEST) && selftest_fatal;
   wire is_oper = (state_reg == led_seq_pkg::ST_OPER);
   wire is_self = (state_reg == led_seq_pkg::ST_SELFTEST);
   wire mon_fatal = (state_reg == led_seq_pkg::ST_MONITOR) && fatal_reg;
   wire ready_use = ctrl_reg[led_seq_pkg::CTRL_READY_BIT];

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         led_seq_pkg::ST_SELFTEST: begin
            if (selftest_fatal || force_mon) begin
               state_next = led_seq_pkg::ST_MONITOR;
            end else if (selftest_done) begin
               state_next = led_seq_pkg::ST_OPER;
            end
         end
         led_seq_pkg::ST_OPER: begin
            if (force_mon) begin
               state_next = led_seq_pkg::ST_MONITOR;
            end
         end
         led_seq_pkg::ST_MONITOR: state_next = led_seq_pkg::ST_MONITOR;
         default: state_next = led_seq_pkg::ST_SELFTEST;
      endcase
   end

   blink_code_if code_bus ();
   assign code_bus.tick = tick_reg;
   assign code_bus.enable = mon_fatal;
   assign code_bus.code = code_reg;

   blink_code_gen u_code (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(code_bus)
   );

   // ------------------------------------------------------------
   // unit status led
   // ------------------------------------------------------------
   wire [1:0] oper_unit =
      (hub_fail && cfg_fallback) ? (blink1 ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_YELLOW) :
      hub_fail ? (blink1 ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_OFF) :
      cfg_fallback ? (blink1 ? led_seq_pkg::COL_GREEN : led_seq_pkg::COL_YELLOW) :
      (ready_use && !blink1) ? led_seq_pkg::COL_OFF : led_seq_pkg::COL_GREEN;
   wire [1:0] fast_yellow = blink5 ? led_seq_pkg::COL_YELLOW : led_seq_pkg::COL_OFF;
   wire [1:0] code_col = code_bus.led_on ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_OFF;
   wire [1:0] unit_next = is_self ? fast_yellow : is_oper ? oper_unit : fatal_reg ? code_col : fast_yellow;

   // ------------------------------------------------------------
   // hub port leds
   // ------------------------------------------------------------
   logic [2*HUB_PORTS-1:0] hub_next;
   generate
      for (g = 0; g < HUB_PORTS; g++) begin : g_hub
         wire [1:0] cyc = (step_reg == 2'h1) ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_OFF;
         wire [1:0] self_col = hub_selftest_err[g] ? led_seq_pkg::COL_ORANGE : cyc;
         wire fault = hub_rate_err[g] || hub_polarity_err[g];
         wire [1:0] run_col = fault ? led_seq_pkg::COL_ORANGE :
            hub_link[g] ? led_seq_pkg::COL_GREEN : led_seq_pkg::COL_OFF;
         assign hub_next[2*g+1:2*g] = is_self ? self_col : mon_fatal ? led_seq_pkg::COL_ORANGE : run_col;
      end
   endgenerate

   // ------------------------------------------------------------
   // serial port leds
   // ------------------------------------------------------------
   logic [2*SERIAL_PORTS-1:0] serial_next;
   generate
      for (g = 0; g < SERIAL_PORTS; g++) begin : g_ser
         logic [7:0] act_reg, err_reg;
         wire act_start = serial_activity[g] && (act_reg == 8'h00);
         wire act_dark = act_reg > led_seq_pkg::ACT_DARK_MS;
         wire err_start = is_oper && serial_open[g] && serial_line_err[g];
         wire [1:0] cyc = (step_reg == 2'h1) ? led_seq_pkg::COL_GREEN :
            (step_reg == 2'h2) ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_OFF;
         wire [1:0] self_col = serial_selftest_err[g] ? led_seq_pkg::COL_ORANGE : cyc;
         wire [1:0] run_col = !serial_open[g] ? led_seq_pkg::COL_OFF :
            act_dark ? led_seq_pkg::COL_OFF :
            serial_op_err[g] ? led_seq_pkg::COL_ORANGE :
            (err_reg != 8'h00) ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_GREEN;
         wire [1:0] mon_col = fatal_reg ? led_seq_pkg::COL_ORANGE : led_seq_pkg::COL_OFF;
         assign serial_next[2*g+1:2*g] = is_self ? self_col : is_oper ? run_col : mon_col;
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               act_reg <= 8'h00;
               err_reg <= 8'h00;
            end else begin
               act_reg <= act_start ? led_seq_pkg::ACT_PERIOD_MS :
                  (tick_reg && act_reg != 8'h00) ? act_reg - 8'h01 : act_reg;
               err_reg <= err_start ? led_seq_pkg::ERR_BLINK_MS :
                  (tick_reg && err_reg != 8'h00) ? err_reg - 8'h01 : err_reg;
            end
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // interrupt events
   // ------------------------------------------------------------
   logic [3:0] irq_event;
   assign irq_event[led_seq_pkg::IRQ_OPER_BIT] = is_self && (state_next == led_seq_pkg::ST_OPER);
   assign irq_event[led_seq_pkg::IRQ_MONITOR_BIT] = !(state_reg == led_seq_pkg::ST_MONITOR) &&
      (state_next == led_seq_pkg::ST_MONITOR);
   assign irq_event[led_seq_pkg::IRQ_HUB_BIT] = hub_fail && !hub_fail_d_reg;
   assign irq_event[led_seq_pkg::IRQ_SERIAL_BIT] = is_oper && |(serial_line_err & serial_open);

   wire [3:0] clr_mask = wr_clear ? wdata_reg[3:0] : 4'h0;
   wire [3:0] irq_status_next = irq_event | (irq_status_reg & ~clr_mask);

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   wire [31:0] state_word = {14'h0000, unit_led, code_reg, 5'h00, fatal_reg, 2'(state_reg)};
   wire [31:0] rd_word = (rd_idx == 3'h1) ? {30'h00000000, ctrl_reg} :
      (rd_idx == 3'h2) ? state_word :
      (rd_idx == 3'h3) ? {28'h0000000, irq_status_reg} :
      (rd_idx == 3'h5) ? {28'h0000000, irq_enable_reg} : 32'h00000000;
   wire rd_ok = (rd_idx != 3'h0);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_reg <= led_seq_pkg::ST_SELFTEST;
         fatal_reg <= 1'b0;
         code_reg <= 8'h00;
         debug_d_reg <= 1'b0;
         hub_fail_d_reg <= 1'b0;
         unit_led <= led_seq_pkg::COL_OFF;
         hub_led <= '0;
         serial_led <= '0;
      end else begin
         state_reg <= state_next;
         fatal_reg <= fatal_reg || fatal_hit;
         code_reg <= fatal_hit ? fatal_code : code_reg;
         debug_d_reg <= debug_button;
         hub_fail_d_reg <= hub_fail;
         unit_led <= unit_next;
         hub_led <= hub_next;
         serial_led <= serial_next;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_reg <= led_seq_pkg::CTRL_RESET;
         irq_status_reg <= led_seq_pkg::IRQ_RESET;
         irq_enable_reg <= led_seq_pkg::IRQ_RESET;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= wr_ctrl ? wdata_reg[1:0] : ctrl_reg;
         irq_status_reg <= irq_status_next;
         irq_enable_reg <= wr_enable ? wdata_reg[3:0] : irq_enable_reg;
         irq_reg <= |(irq_status_next & (wr_enable ? wdata_reg[3:0] : irq_enable_reg));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_reg <= 1'b1;
         wready_reg <= 1'b1;
         bvalid_reg <= 1'b0;
         bresp_reg <= led_seq_pkg::RESP_OKAY;
         awaddr_reg <= '0;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
      end else begin
         if (s_axi_awvalid && awready_reg) begin
            awaddr_reg <= s_axi_awaddr;
            awready_reg <= 1'b0;
         end
         if (s_axi_wvalid && wready_reg) begin
            wdata_reg <= s_axi_wdata;
            wstrb_reg <= s_axi_wstrb;
            wready_reg <= 1'b0;
         end
         if (do_write) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? led_seq_pkg::RESP_OKAY : led_seq_pkg::RESP_SLVERR;
         end
         if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h00000000;
         rresp_reg <= led_seq_pkg::RESP_OKAY;
      end else if (rd_take) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b1;
         rdata_reg <= rd_word;
         rresp_reg <= rd_ok ? led_seq_pkg::RESP_OKAY : led_seq_pkg::RESP_SLVERR;
      end else if (rvalid_reg && s_axi_rready) begin
         arready_reg <= 1'b1;
         rvalid_reg <= 1'b0;
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rdata = rdata_reg;
   assign s_axi_rresp = rresp_reg;
   assign irq = irq_reg;

endmodule

// ### status_led_monitor.sv
// port checks of the indicator sequencer
`timescale 1ns/1ps
module status_led_monitor #(parameter int HUB_PORTS = 4) (
   input wire logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
   input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready,
   input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
   input wire logic [1:0] s_axi_bresp, s_axi_rresp, unit_led,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [HUB_PORTS-1:0] hub_rate_err, hub_polarity_err,
   input wire logic [2*HUB_PORTS-1:0] hub_led
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_aw_closed: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready) else $error("awready stayed");
   a_w_closed: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready) else $error("wready stayed");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
   a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'h014
      |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0) else $error("unmapped read accepted");
   a_write_readonly: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      && s_axi_awaddr == 12'h004 |-> ##[1:2] s_axi_bvalid && s_axi_bresp == 2'h2) else $error("read-only written");
   a_hub_fault_lit: assert property (unit_led == 2'h1 && (hub_rate_err[0] || hub_polarity_err[0])
      |=> hub_led[1:0] == 2'h3) else $error("hub fault not orange");
   cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
   cover property (unit_led == 2'h3);
   cover property (hub_led[1:0] == 2'h3 && unit_led == 2'h1);
endmodule

// ### led_panel_model.sv
// front panel lamp: colours seen and onsets of one colour
`timescale 1ns/1ps
module led_panel_model (
   input wire logic aclk, clr,
   input wire logic [1:0] led, col,
   output logic [3:0] seen,
   output logic [7:0] lits
);
   logic [1:0] last;
   always_ff @(posedge aclk) begin
      last <= led;
      if (clr) begin
         seen <= 4'h0;
         lits <= 8'h0;
      end else begin
         seen[led] <= 1'h1;
         if (led == col && last != col) lits <= lits + 8'h1;
      end
   end
endmodule

// ### tb_status_led_indicator_sequencer.sv
// self-checking bench of the indicator sequencer
`timescale 1ns/1ps
module tb_status_led_indicator_sequencer;
   logic aclk = 1'h0, aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, selftest_done = 1'h0, selftest_fatal = 1'h0;
   logic debug_button = 1'h0, cfg_fallback = 1'h0, hub_fail = 1'h0, clr = 1'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic [3:0] s_axi_wstrb = 4'hF, hub_selftest_err = 4'h0, hub_rate_err = 4'h0, hub_polarity_err = 4'h0;
   logic [3:0] hub_link = 4'h0, unit_seen, port_seen;
   logic [7:0] fatal_code = 8'h0, serial_selftest_err = 8'h0, serial_open = 8'h0, serial_activity = 8'h0;
   logic [7:0] serial_line_err = 8'h0, serial_op_err = 8'h0, hub_led, unit_lits, port_lits;
   logic [1:0] s_axi_bresp, s_axi_rresp, unit_led, rsp;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
   logic [15:0] serial_led;
   int fail_count = 0, tests_run = 0, pidx = 0;
   typedef struct {logic cfg; logic hub; logic [3:0] mask;} row_t;
   row_t rows[5] = '{'{1'h0, 1'h0, 4'h2}, '{1'h1, 1'h0, 4'h6}, '{1'h0, 1'h1, 4'h9}, '{1'h1, 1'h1, 4'hC},
      '{1'h0, 1'h0, 4'h2}};
   status_led_indicator_sequencer #(.TICK_CYCLES(4)) status_led_indicator_sequencer_inst (.*);
   led_panel_model unit_lamp (.aclk, .clr, .led(unit_led), .col(2'h3), .seen(unit_seen), .lits(unit_lits));
   led_panel_model port_lamp (.aclk, .clr, .led(serial_led[2*pidx+:2]), .col(2'h1), .seen(port_seen),
      .lits(port_lits));
   initial forever #2 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      if (fail_count == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (!s_axi_rvalid);
      rsp = s_axi_rresp;
      rdat = s_axi_rdata;
      s_axi_rready <= 1'h0;
   endtask
   task automatic watch(input int n);
      clr <= 1'h1;
      @(posedge aclk);
      clr <= 1'h0;
      repeat (n) @(posedge aclk);
   endtask
   task automatic do_reset;
      aresetn <= 1'h0;
      repeat (4) @(posedge aclk);
      chk(unit_led, 0);
      chk(irq, 0);
      aresetn <= 1'h1;
   endtask
   initial begin
      #400000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      do_reset;
      rd(12'h000);
      chk(rdat, 0);
      rd(12'h010);
      chk(rdat, 0);
      hub_selftest_err[1] <= 1'h1;
      serial_selftest_err[2] <= 1'h1;
      watch(1000);
      chk(unit_seen, 4'h5);
      chk(hub_led[3:2], 2'h3);
      chk(serial_led[5:4], 2'h3);
      wr(12'h010, 32'h1);
      selftest_done <= 1'h1;
      repeat (4) @(posedge aclk);
      chk(irq, 1);
      rd(12'h004);
      chk(rdat[1:0], 2'h1);
      wr(12'h00C, 32'h1);
      wr(12'h010, 32'h0);
      chk(irq, 0);
      for (int i = 0; i < 5; i++) begin
         cfg_fallback <= rows[i].cfg;
         hub_fail <= rows[i].hub;
         repeat (4) @(posedge aclk);
         watch(4200);
         chk(unit_seen, rows[i].mask);
      end
      rd(12'h008);
      chk(rdat, 32'h4);
      chk(irq, 0);
      wr(12'h010, 32'h4);
      repeat (2) @(posedge aclk);
      chk(irq, 1);
      wr(12'h00C, 32'h4);
      repeat (2) @(posedge aclk);
      chk(irq, 0);
      wr(12'h014, 32'h1);
      chk(rsp, 2'h2);
      wr(12'h004, 32'h0);
      chk(rsp, 2'h2);
      rd(12'h014);
      chk(rsp, 2'h2);
      wr(12'h000, 32'h1);
      watch(4200);
      chk(unit_seen, 4'h3);
      hub_rate_err[0] <= 1'h1;
      hub_polarity_err[3] <= 1'h1;
      serial_open <= 8'h07;
      repeat (3) @(posedge aclk);
      chk({hub_led[7:6], hub_led[1:0]}, 4'hF);
      serial_activity[0] <= 1'h1;
      watch(4000);
      chk(port_lits, 5);
      pidx = 1;
      serial_line_err[1] <= 1'h1;
      @(posedge aclk);
      serial_line_err[1] <= 1'h0;
      watch(1000);
      chk(port_seen, 4'hA);
      pidx = 2;
      serial_op_err[2] <= 1'h1;
      serial_activity[2] <= 1'h1;
      watch(1000);
      chk(port_seen, 4'h9);
      wr(12'h000, 32'h2);
      rd(12'h004);
      chk(rdat[1:0], 2'h2);
      selftest_done <= 1'h0;
      do_reset;
      fatal_code <= 8'h21;
      selftest_fatal <= 1'h1;
      watch(21000);
      chk(unit_lits, 6);
      chk(hub_led, 8'hFF);
      selftest_fatal <= 1'h0;
      do_reset;
      pidx = 0;
      debug_button <= 1'h1;
      watch(1200);
      chk(unit_seen, 4'h5);
      chk(port_seen, 4'h1);
      report_and_stop;
   end
endmodule
bind status_led_indicator_sequencer status_led_monitor #(.HUB_PORTS(HUB_PORTS)) status_led_monitor_inst (.aclk,
   .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_awaddr, .s_axi_araddr, .s_axi_bresp,
   .s_axi_rresp, .unit_led, .s_axi_rdata, .hub_rate_err, .hub_polarity_err, .hub_led);
